// >>> core/dpram_host.sv
// Host controller driving one port of a dual-port RAM with token flags
`timescale 1ns/1ps
`include "dpram_host_regs.svh"

// Functional notes
// - Flags active low: write zero to request, one to release.
// - Polling host drops select or output enable between reads.
// - Acquire is write zero then read back; zero means success.
// - After a failed request keep reading or write one to withdraw.
// - Flags are not reset; host writes one to all eight at start.
// - Host keeps strobe or memory select high while address changes.
// - Exactly one select low, held through the whole write overlap.
// - Host waits the write-to-read time before the verifying flag read.
module dpram_host
    import dpram_host_pkg::*;
#(
    parameter logic [7:0] POLL_MAX = 8'h04
) (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rst,
    // Command side
    input  wire logic               cmd_valid,
    output logic                    cmd_ready,
    input  wire cmd_t               cmd,
    // Answer side
    output logic                    rsp_valid,
    output rsp_t                    rsp,
    output logic                    init_done,
    // Device port pins
    output logic [`ADDR_W-1:0]      addr_o,
    output logic                    mem_select_n,
    output logic                    flag_space_select_n,
    output logic                    rw_n,
    output logic                    oe_n,
    output logic [`DATA_W-1:0]      data_o,
    output logic                    data_oe,
    input  wire logic [`DATA_W-1:0] data_i
);

    state_t                  state_q,     state_d;
    op_t                     op_q,        op_d;
    logic [3:0]              cnt_q,       cnt_d;
    logic [`ADDR_W-1:0]      addr_q,      addr_d;
    logic [`DATA_W-1:0]      dout_q,      dout_d;
    logic [`DATA_W-1:0]      rdata_q,     rdata_d;
    logic [`FLAG_IDX_W-1:0]  idx_q,       idx_d;
    logic [7:0]              polls_q,     polls_d;
    logic                    acc_wr_q,    acc_wr_d;
    logic                    acc_flag_q,  acc_flag_d;
    logic                    init_done_q, init_done_d;
    logic                    granted_q,   granted_d;
    logic                    wrote_zero_q, wrote_zero_d;
    logic                    withdrew_q,  withdrew_d;
    pins_t                   pins_q,      pins_d;

    function automatic logic [3:0] to_cnt(input int v);
        to_cnt = v[3:0];
    endfunction : to_cnt

    // Only the low index bits select a flag
    function automatic logic [`ADDR_W-1:0] flag_addr(input logic [`FLAG_IDX_W-1:0] idx);
        flag_addr = {{(`ADDR_W-`FLAG_IDX_W){1'b0}}, idx};
    endfunction : flag_addr

    // Pin levels for a given phase; exactly one select low while active
    function automatic pins_t pin_drive(input state_t st, input logic wr, input logic flg,
                                        input logic [`ADDR_W-1:0] a,
                                        input logic [`DATA_W-1:0] d);
        pins_t p;
        p.addr                = a;
        p.dout                = d;
        p.mem_select_n        = 1'b1;
        p.flag_space_select_n = 1'b1;
        p.rw_n                = 1'b1;
        p.oe_n                = 1'b1;
        p.dout_oe             = 1'b0;
        if (st == S_SETUP || st == S_WRITE || st == S_HOLD || st == S_READ) begin
            p.mem_select_n        = flg;
            p.flag_space_select_n = ~flg;
        end
        case (st)
            S_SETUP: p.dout_oe = wr;
            S_WRITE: begin
                p.rw_n    = 1'b0;
                p.dout_oe = 1'b1;
            end
            S_HOLD:  p.dout_oe = 1'b1;
            S_READ:  p.oe_n = 1'b0;
            default: p.dout_oe = 1'b0;
        endcase
        pin_drive = p;
    endfunction : pin_drive

    always_comb begin
        state_d      = state_q;
        op_d         = op_q;
        cnt_d        = cnt_q;
        addr_d       = addr_q;
        dout_d       = dout_q;
        rdata_d      = rdata_q;
        idx_d        = idx_q;
        polls_d      = polls_q;
        acc_wr_d     = acc_wr_q;
        acc_flag_d   = acc_flag_q;
        init_done_d  = init_done_q;
        granted_d    = granted_q;
        wrote_zero_d = wrote_zero_q;
        withdrew_d   = withdrew_q;
        case (state_q)
            S_IDLE: begin
                if (!init_done_q || cmd_valid) begin
                    op_d         = init_done_q ? cmd.op : OP_INIT;
                    addr_d       = cmd.addr;
                    dout_d       = cmd.data;
                    polls_d      = 8'h00;
                    idx_d        = '0;
                    granted_d    = 1'b0;
                    wrote_zero_d = 1'b0;
                    withdrew_d   = 1'b0;
                    acc_wr_d     = 1'b1;
                    acc_flag_d   = 1'b1;
                    state_d      = S_SETUP;
                    case (op_d)
                        OP_MEM_RD: begin
                            acc_wr_d   = 1'b0;
                            acc_flag_d = 1'b0;
                        end
                        OP_MEM_WR: acc_flag_d = 1'b0;
                        OP_FLAG_RD: begin
                            acc_wr_d = 1'b0;
                            addr_d   = flag_addr(cmd.addr[`FLAG_IDX_W-1:0]);
                        end
                        OP_FLAG_WR: begin
                            addr_d = flag_addr(cmd.addr[`FLAG_IDX_W-1:0]);
                            dout_d = {`DATA_W{cmd.data[0]}};
                        end
                        OP_ACQUIRE: begin
                            addr_d = flag_addr(cmd.addr[`FLAG_IDX_W-1:0]);
                            dout_d = `DATA_ZERO;
                        end
                        OP_RELEASE: begin
                            addr_d = flag_addr(cmd.addr[`FLAG_IDX_W-1:0]);
                            dout_d = `DATA_ONES;
                        end
                        default: begin
                            addr_d = flag_addr('0);
                            dout_d = `DATA_ONES;
                        end
                    endcase
                end
            end
            S_SETUP: begin
                cnt_d   = acc_wr_q ? to_cnt(`WP_CYC - 1) : to_cnt(`RD_CYC - 1);
                state_d = acc_wr_q ? S_WRITE : S_READ;
            end
            S_WRITE: begin
                if (cnt_q == 4'h0) begin
                    state_d = S_HOLD;
                end else begin
                    cnt_d = cnt_q - 4'h1;
                end
            end
            S_HOLD: begin
                // Strobe rises here with the select still low
                state_d = S_GAP;
                cnt_d   = to_cnt(`GAP_CYC - 1);
                if (op_q == OP_ACQUIRE && dout_q == `DATA_ZERO) begin
                    wrote_zero_d = 1'b1;
                end
                if (op_q == OP_ACQUIRE && dout_q == `DATA_ONES) begin
                    withdrew_d = 1'b1;
                end
            end
            S_READ: begin
                if (cnt_q == 4'h0) begin
                    rdata_d = data_i;
                    state_d = S_GAP;
                    cnt_d   = to_cnt(`GAP_CYC - 1);
                end else begin
                    cnt_d = cnt_q - 4'h1;
                end
            end
            S_GAP: begin
                if (cnt_q != 4'h0) begin
                    cnt_d = cnt_q - 4'h1;
                end else begin
                    state_d = S_DONE;
                    case (op_q)
                        OP_INIT: begin
                            if (idx_q == `FLAG_LAST) begin
                                init_done_d = 1'b1;
                            end else begin
                                idx_d   = idx_q + 3'h1;
                                addr_d  = flag_addr(idx_q + 3'h1);
                                state_d = S_SETUP;
                            end
                        end
                        OP_ACQUIRE: begin
                            if (acc_wr_q) begin
                                if (!withdrew_q) begin
                                    acc_wr_d = 1'b0;
                                    state_d  = S_SETUP;
                                end
                            end else if (rdata_q[0] == 1'b0) begin
                                granted_d = 1'b1;
                            end else if (polls_q < POLL_MAX - 8'h01) begin
                                polls_d = polls_q + 8'h01;
                                state_d = S_SETUP;
                            end else begin
                                acc_wr_d = 1'b1;
                                dout_d   = `DATA_ONES;
                                state_d  = S_SETUP;
                            end
                        end
                        default: state_d = S_DONE;
                    endcase
                end
            end
            S_DONE:  state_d = S_IDLE;
            default: state_d = S_IDLE;
        endcase
        pins_d = pin_drive(state_d, acc_wr_d, acc_flag_d, addr_d, dout_d);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q      <= S_IDLE;
            op_q         <= OP_INIT;
            cnt_q        <= 4'h0;
            addr_q       <= '0;
            dout_q       <= '0;
            rdata_q      <= '0;
            idx_q        <= '0;
            polls_q      <= 8'h00;
            acc_wr_q     <= 1'b0;
            acc_flag_q   <= 1'b0;
            init_done_q  <= 1'b0;
            granted_q    <= 1'b0;
            wrote_zero_q <= 1'b0;
            withdrew_q   <= 1'b0;
            pins_q       <= '{addr: '0, mem_select_n: 1'b1, flag_space_select_n: 1'b1,
                              rw_n: 1'b1, oe_n: 1'b1, dout: '0, dout_oe: 1'b0};
        end else begin
            state_q      <= state_d;
            op_q         <= op_d;
            cnt_q        <= cnt_d;
            addr_q       <= addr_d;
            dout_q       <= dout_d;
            rdata_q      <= rdata_d;
            idx_q        <= idx_d;
            polls_q      <= polls_d;
            acc_wr_q     <= acc_wr_d;
            acc_flag_q   <= acc_flag_d;
            init_done_q  <= init_done_d;
            granted_q    <= granted_d;
            wrote_zero_q <= wrote_zero_d;
            withdrew_q   <= withdrew_d;
            pins_q       <= pins_d;
        end
    end

    assign cmd_ready           = (state_q == S_IDLE) && init_done_q;
    assign rsp_valid           = (state_q == S_DONE) && (op_q != OP_INIT || init_done_q);
    assign rsp                 = '{data: rdata_q, granted: granted_q};
    assign init_done           = init_done_q;
    assign addr_o              = pins_q.addr;
    assign mem_select_n        = pins_q.mem_select_n;
    assign flag_space_select_n = pins_q.flag_space_select_n;
    assign rw_n                = pins_q.rw_n;
    assign oe_n                = pins_q.oe_n;
    assign data_o              = pins_q.dout;
    assign data_oe             = pins_q.dout_oe;

    chk_addr_change_safe: assert property (@(posedge clk) disable iff (rst)
        !$stable(pins_q.addr) |-> pins_q.rw_n && $past(pins_q.rw_n))
        else $error("address moved while strobe low");
    chk_single_select: assert property (@(posedge clk) disable iff (rst)
        !(pins_q.mem_select_n == 1'b0 && pins_q.flag_space_select_n == 1'b0))
        else $error("both selects low");
    chk_select_held_write: assert property (@(posedge clk) disable iff (rst)
        $rose(pins_q.rw_n) |-> $stable(pins_q.mem_select_n)
                               && $stable(pins_q.flag_space_select_n))
        else $error("select changed at end of write");
    chk_write_qualified: assert property (@(posedge clk) disable iff (rst)
        !pins_q.rw_n |-> pins_q.dout_oe && (!pins_q.mem_select_n || !pins_q.flag_space_select_n))
        else $error("write strobe without select or data");
    chk_write_pulse_len: assert property (@(posedge clk) disable iff (rst)
        $fell(pins_q.rw_n) |-> (!pins_q.rw_n)[*2] ##1 pins_q.rw_n)
        else $error("write pulse length wrong");
    chk_write_read_gap: assert property (@(posedge clk) disable iff (rst)
        ($rose(pins_q.rw_n) && !pins_q.flag_space_select_n) |-> ##1 (pins_q.oe_n)[*3])
        else $error("flag read too soon after write");
    chk_poll_deselect: assert property (@(posedge clk) disable iff (rst)
        ($fell(pins_q.oe_n) && !pins_q.flag_space_select_n)
            |-> $past(pins_q.flag_space_select_n, 2))
        else $error("flag read without deselect");
    chk_acquire_order: assert property (@(posedge clk) disable iff (rst)
        (state_q == S_READ && op_q == OP_ACQUIRE) |-> wrote_zero_q)
        else $error("acquire read before request write");
    chk_failed_withdraw: assert property (@(posedge clk) disable iff (rst)
        (rsp_valid && op_q == OP_ACQUIRE && !rsp.granted) |-> withdrew_q)
        else $error("failed acquire left request pending");
    chk_init_writes_one: assert property (@(posedge clk) disable iff (rst)
        (!pins_q.rw_n && op_q == OP_INIT) |-> pins_q.dout == `DATA_ONES
                                              && !pins_q.flag_space_select_n)
        else $error("init write not a release");
    chk_ready_after_init: assert property (@(posedge clk) disable iff (rst)
        $rose(init_done_q) |-> idx_q == `FLAG_LAST && op_q == OP_INIT)
        else $error("init finished before last flag written");

    cov_acquire_won:  cover property (@(posedge clk) disable iff (rst)
        rsp_valid && op_q == OP_ACQUIRE && rsp.granted);
    cov_acquire_lost: cover property (@(posedge clk) disable iff (rst)
        rsp_valid && op_q == OP_ACQUIRE && !rsp.granted);
    cov_mem_write:    cover property (@(posedge clk) disable iff (rst)
        rsp_valid && op_q == OP_MEM_WR);
    cov_init_done:    cover property (@(posedge clk) disable iff (rst)
        $rose(init_done_q));

endmodule : dpram_host

// >>> core/dpram_host_regs.svh
// Pin timing counts, widths and flag constants for the dual-port RAM host controller
`ifndef DPRAM_HOST_REGS_SVH
`define DPRAM_HOST_REGS_SVH

`define ADDR_W        12
`define DATA_W        8
`define FLAG_COUNT    8
`define FLAG_IDX_W    3
`define FLAG_LAST     3'h7
`define DATA_ONES     8'hFF
`define DATA_ZERO     8'h00

`define CLK_PERIOD_NS 8
`define T_WP_NS       15
`define T_ACC_NS      20
`define T_SWR_NS      10

// Least times round up to whole cycles
`define CEIL_CYC(t)   (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WP_CYC        `CEIL_CYC(`T_WP_NS)
`define RD_CYC        (`CEIL_CYC(`T_ACC_NS) + 1)
`define GAP_CYC       `CEIL_CYC(`T_SWR_NS)

`endif

// >>> core/dpram_host_pkg.sv
// Types shared by the dual-port RAM host controller
`include "dpram_host_regs.svh"

package dpram_host_pkg;

    typedef enum logic [2:0] {
        OP_MEM_RD  = 3'h0,
        OP_MEM_WR  = 3'h1,
        OP_FLAG_RD = 3'h2,
        OP_FLAG_WR = 3'h3,
        OP_ACQUIRE = 3'h4,
        OP_RELEASE = 3'h5,
        OP_INIT    = 3'h6
    } op_t;

    typedef enum logic [6:0] {
        S_IDLE  = 7'h01,
        S_SETUP = 7'h02,
        S_WRITE = 7'h04,
        S_HOLD  = 7'h08,
        S_READ  = 7'h10,
        S_GAP   = 7'h20,
        S_DONE  = 7'h40
    } state_t;

    typedef struct packed {
        op_t                 op;
        logic [`ADDR_W-1:0]  addr;
        logic [`DATA_W-1:0]  data;
    } cmd_t;

    typedef struct packed {
        logic [`DATA_W-1:0]  data;
        logic                granted;
    } rsp_t;

    typedef struct packed {
        logic [`ADDR_W-1:0]  addr;
        logic                mem_select_n;
        logic                flag_space_select_n;
        logic                rw_n;
        logic                oe_n;
        logic [`DATA_W-1:0]  dout;
        logic                dout_oe;
    } pins_t;

endpackage : dpram_host_pkg

// >>> sim/dpram_port_model.sv
// Behavioural dual-port RAM with eight token flags, one host port and one far port
`timescale 1ns/1ps
module dpram_port_model (
    // Host-side port
    input  wire logic [11:0] a_addr,
    input  wire logic        a_mem_n,
    input  wire logic        a_flag_n,
    input  wire logic        a_rw_n,
    input  wire logic        a_oe_n,
    input  wire logic [7:0]  a_din,
    output logic      [7:0]  a_dout,
    // Far port
    input  wire logic [11:0] b_addr,
    input  wire logic        b_mem_n,
    input  wire logic        b_flag_n,
    input  wire logic        b_rw_n,
    input  wire logic        b_oe_n,
    input  wire logic [7:0]  b_din,
    output logic      [7:0]  b_dout
);
    logic [7:0] mem [4096];
    // Stale power-up state: host side holds every token
    logic [7:0] req_a   = 8'h00;
    logic [7:0] req_b   = 8'hFF;
    logic [7:0] own_a   = 8'hFF;
    logic [7:0] own_b   = 8'h00;
    logic [7:0] a_latch = 8'hFF;
    logic [7:0] b_latch = 8'hFF;
    logic [7:0] a_keep  = 8'h00;
    logic [7:0] b_keep  = 8'h00;

    task automatic settle(input logic [2:0] i, input logic from_b);
        if (own_a[i] && req_a[i]) own_a[i] = 1'b0;
        if (own_b[i] && req_b[i]) own_b[i] = 1'b0;
        if (!own_a[i] && !own_b[i]) begin
            if (!req_a[i] && (!from_b || req_b[i])) own_a[i] = 1'b1;
            else if (!req_b[i]) own_b[i] = 1'b1;
        end
    endtask : settle

    // Each port acts on its own strobe only
    always @(posedge a_rw_n) begin
        if (a_mem_n === 1'b0 && a_flag_n === 1'b1) mem[a_addr] = a_din;
        else if (a_mem_n === 1'b1 && a_flag_n === 1'b0) begin
            req_a[a_addr[2:0]] = a_din[0];
            settle(a_addr[2:0], 1'b0);
        end
    end
    always @(posedge b_rw_n) begin
        if (b_mem_n === 1'b0 && b_flag_n === 1'b1) mem[b_addr] = b_din;
        else if (b_mem_n === 1'b1 && b_flag_n === 1'b0) begin
            req_b[b_addr[2:0]] = b_din[0];
            settle(b_addr[2:0], 1'b1);
        end
    end

    wire       a_rd  = !a_flag_n && a_mem_n && !a_oe_n;
    wire       b_rd  = !b_flag_n && b_mem_n && !b_oe_n;
    wire       a_on  = !(a_mem_n && a_flag_n) && !a_oe_n;
    wire       b_on  = !(b_mem_n && b_flag_n) && !b_oe_n;
    wire [7:0] a_val = a_flag_n ? mem[a_addr] : a_latch;
    wire [7:0] b_val = b_flag_n ? mem[b_addr] : b_latch;
    always @(posedge a_rd) a_latch = {8{~own_a[a_addr[2:0]]}};
    always @(posedge b_rd) b_latch = {8{~own_b[b_addr[2:0]]}};
    always @(a_on or a_val) if (a_on) a_keep = a_val;
    always @(b_on or b_val) if (b_on) b_keep = b_val;
    // A floating bus shows the inverse of its last value
    assign a_dout = a_on ? a_val : ~a_keep;
    assign b_dout = b_on ? b_val : ~b_keep;
endmodule : dpram_port_model

// >>> sim/test_dual_port_ram_semaphore_flags.sv
// Self-checking bench: host controller against the dual-port RAM model
`timescale 1ns/1ps
module test_dual_port_ram_semaphore_flags
    import dpram_host_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        cmd_valid = 1'b0;
    cmd_t        cmd = '0;
    logic        cmd_ready, rsp_valid, init_done;
    rsp_t        rsp;
    logic [11:0] addr_o;
    logic        mem_select_n, flag_space_select_n, rw_n, oe_n, data_oe;
    logic [7:0]  data_o, data_i;
    logic [11:0] b_addr = 12'h000;
    logic        b_flag_n = 1'b1;
    logic        b_rw_n = 1'b1;
    logic        b_oe_n = 1'b1;
    logic [7:0]  b_din = 8'h00;
    logic [7:0]  b_dout;
    int          miscompares = 0;
    int          checks = 0;
    int          cycles = 0;

    dpram_host #(.POLL_MAX(8'h02)) DUT (
        .clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
        .rsp_valid(rsp_valid), .rsp(rsp), .init_done(init_done), .addr_o(addr_o),
        .mem_select_n(mem_select_n), .flag_space_select_n(flag_space_select_n),
        .rw_n(rw_n), .oe_n(oe_n), .data_o(data_o), .data_oe(data_oe), .data_i(data_i)
    );
    dpram_port_model ram (
        .a_addr(addr_o), .a_mem_n(mem_select_n), .a_flag_n(flag_space_select_n),
        .a_rw_n(rw_n), .a_oe_n(oe_n), .a_din(data_oe ? data_o : ~data_o), .a_dout(data_i),
        .b_addr(b_addr), .b_mem_n(1'b1), .b_flag_n(b_flag_n), .b_rw_n(b_rw_n),
        .b_oe_n(b_oe_n), .b_din(b_din), .b_dout(b_dout)
    );

    initial forever #4 clk = ~clk;

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            $display("[ERR] %0t run did not finish in time", $time);
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : wrap_up

    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t byte %h expected %h", $time, got, exp);
        end
    endtask : check_byte

    task automatic check_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t bit %b expected %b", $time, got, exp);
        end
    endtask : check_bit

    // One command, held until taken, then wait for its answer
    task automatic issue(input op_t op, input logic [11:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        #1;
        cmd_valid = 1'b1;
        cmd = '{op: op, addr: a, data: d};
        do begin
            @(posedge clk);
            n++;
        end while (cmd_ready !== 1'b1 && n < 200);
        #1;
        cmd_valid = 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (rsp_valid !== 1'b1 && n < 200);
        check_bit(rsp_valid, 1'b1);
    endtask : issue

    task automatic b_write(input logic [2:0] i, input logic v);
        b_addr = {9'h000, i};
        b_din = {7'h00, v};
        b_flag_n = 1'b0;
        b_rw_n = 1'b0;
        #20 b_rw_n = 1'b1;
        #5 b_flag_n = 1'b1;
        #15;
    endtask : b_write

    task automatic b_read(input logic [2:0] i, output logic [7:0] v);
        b_addr = {9'h000, i};
        b_flag_n = 1'b0;
        b_oe_n = 1'b0;
        #25 v = b_dout;
        b_flag_n = 1'b1;
        b_oe_n = 1'b1;
        #15;
    endtask : b_read

    task automatic t_init();
        int n;
        logic [7:0] v;
        n = 0;
        for (int i = 0; i < 8; i++) b_write(i[2:0], 1'b1);
        while (init_done !== 1'b1 && n < 500) begin
            @(posedge clk);
            n++;
        end
        check_bit(init_done, 1'b1);
        repeat (4) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            b_read(i[2:0], v);
            check_byte(v, 8'hFF);
            issue(OP_FLAG_RD, {9'h1FF, i[2:0]}, 8'h00);
            check_byte(rsp.data, 8'hFF);
        end
    endtask : t_init

    task automatic t_acquire();
        logic [7:0] v;
        issue(OP_ACQUIRE, 12'hFF5, 8'h00);
        check_bit(rsp.granted, 1'b1);
        check_byte(rsp.data, 8'h00);
        b_read(3'h5, v);
        check_byte(v, 8'hFF);
        issue(OP_MEM_WR, 12'h005, 8'hC3);
        issue(OP_MEM_RD, 12'h005, 8'h00);
        check_byte(rsp.data, 8'hC3);
        issue(OP_FLAG_RD, 12'h005, 8'h00);
        check_byte(rsp.data, 8'h00);
    endtask : t_acquire

    task automatic t_handover();
        logic [7:0] v;
        b_write(3'h5, 1'b0);
        b_read(3'h5, v);
        check_byte(v, 8'hFF);
        issue(OP_RELEASE, 12'h005, 8'h00);
        b_read(3'h5, v);
        check_byte(v, 8'h00);
        issue(OP_FLAG_RD, 12'h005, 8'h00);
        check_byte(rsp.data, 8'hFF);
        issue(OP_ACQUIRE, 12'h005, 8'h00);
        check_bit(rsp.granted, 1'b0);
        b_write(3'h5, 1'b1);
        b_read(3'h5, v);
        check_byte(v, 8'hFF);
        issue(OP_FLAG_RD, 12'h005, 8'h00);
        check_byte(rsp.data, 8'hFF);
    endtask : t_handover

    task automatic t_bit_zero();
        logic [7:0] v;
        issue(OP_FLAG_WR, 12'h003, 8'hFE);
        issue(OP_FLAG_RD, 12'h003, 8'h00);
        check_byte(rsp.data, 8'h00);
        b_read(3'h3, v);
        check_byte(v, 8'hFF);
        issue(OP_FLAG_WR, 12'h003, 8'h01);
        issue(OP_FLAG_RD, 12'h003, 8'h00);
        check_byte(rsp.data, 8'hFF);
    endtask : t_bit_zero

    task automatic t_contend();
        logic [7:0] v;
        fork
            issue(OP_ACQUIRE, 12'h002, 8'h00);
            begin
                repeat (3) @(posedge clk);
                #6 b_write(3'h2, 1'b0);
            end
        join
        b_read(3'h2, v);
        check_bit((v === 8'h00) ^ rsp.granted, 1'b1);
        issue(OP_RELEASE, 12'h002, 8'h00);
        b_write(3'h2, 1'b1);
        b_read(3'h2, v);
        check_byte(v, 8'hFF);
    endtask : t_contend

    task automatic t_reinit();
        logic [7:0] v;
        issue(OP_ACQUIRE, 12'h007, 8'h00);
        check_bit(rsp.granted, 1'b1);
        issue(OP_INIT, 12'h000, 8'h00);
        b_read(3'h7, v);
        check_byte(v, 8'hFF);
        issue(OP_FLAG_RD, 12'h007, 8'h00);
        check_byte(rsp.data, 8'hFF);
    endtask : t_reinit

    initial begin
        repeat (4) @(posedge clk);
        #1 rst = 1'b0;
        t_init();
        t_acquire();
        t_handover();
        t_bit_zero();
        t_contend();
        t_reinit();
        wrap_up();
    end
endmodule : test_dual_port_ram_semaphore_flags
